// ---- gate_fault_pkg.sv ----
// constants, field layout and timing helpers for the gate driver fault supervisor
package gate_fault_pkg;
	localparam int CLK_NS = 20;
	localparam int CCP_BASE_NS = 587;
	localparam int CCP_STEP_NS = 266;
	localparam int FILT0_NS = 500;
	localparam int FILT1_NS = 1000;
	localparam int FILT2_NS = 2000;
	localparam int FILT3_NS = 6000;
	localparam int TW = 9;
	localparam int NHB = 3;
	localparam int NSYNC = 10;

	localparam logic [7:0] OFS_LS = 8'h00;
	localparam logic [7:0] OFS_HS = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_CCP = 8'h0C;
	localparam logic [7:0] OFS_FAULT = 8'h10;
	localparam logic [7:0] OFS_GSTAT = 8'h14;

	localparam logic [31:0] RST_LS = 32'h00000049;
	localparam logic [31:0] RST_HS = 32'h00000049;
	localparam logic [11:0] RST_CTRL = 12'h000;
	localparam logic [31:0] RST_CCP = 32'h00000000;
	localparam logic [5:0] RST_FAULT = 6'h00;

	localparam int FILT_LSB = 9;
	localparam int PWM_LSB = 6;
	localparam int AFW_LSB = 9;
	localparam int BLK_ACT_LSB = 24;
	localparam int BLK_FW_LSB = 28;
	localparam int HS_FLT_LSB = 3;

	localparam logic [TW-1:0] FILT0_CYC = TW'(FILT0_NS / CLK_NS);
	localparam logic [TW-1:0] FILT1_CYC = TW'(FILT1_NS / CLK_NS);
	localparam logic [TW-1:0] FILT2_CYC = TW'(FILT2_NS / CLK_NS);
	localparam logic [TW-1:0] FILT3_CYC = TW'(FILT3_NS / CLK_NS);

	typedef enum logic [1:0] {
		MODE_FLOAT = 2'b00,
		MODE_LS_ON = 2'b01,
		MODE_HS_ON = 2'b10,
		MODE_OFF = 2'b11
	} drive_t;

	// typical time rounded up so a dead time never comes out short
	function automatic logic [TW-1:0] interval_cycles(input logic [3:0] code);
		int ns;
		ns = CCP_BASE_NS + CCP_STEP_NS * int'(code);
		return TW'((ns + CLK_NS - 1) / CLK_NS);
	endfunction : interval_cycles
endpackage : gate_fault_pkg

// ---- interval_timer.sv ----
// down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ps
module interval_timer
	import gate_fault_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [TW-1:0] len,
	output logic busy
);
	logic [TW-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (start)
			cnt_q <= len;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - TW'(1);
	end

	assign busy = (cnt_q != '0);
endmodule : interval_timer

// ---- gate_fault_supervisor.sv ----
// three half-bridge gate sequencer with drain-source fault supervision and apb registers
`timescale 1ns/1ps
// What this block does
// - low-side overvoltage flags fault, latches bridge off
// - high-side overvoltage flags fault, latches bridge off
// - low-side threshold code, default 001
// - high-side threshold code, same mapping, default 001
// - fault only after blank and filter time
// - filter select 0.5, 1, 2, 6 us
// - fault discharges bridge for dead time, sets status
// - bridge stays off until fault status cleared
// - never both gates of a bridge on
// - per-bridge dead times, 587 ns plus 266 ns steps
// - blank times 587 ns plus 266 ns steps
// - blank starts at turn-on, masks detection
// - pwm gate blank starts after its dead time
// - freewheel gate blank starts after dead time
// - static swap blank starts after dead time
// - from high impedance blank starts at once
// - blank reapplied after supply recovery
// - mode 11 actively off, 01/10 monitored on-states
module gate_fault_supervisor
	import gate_fault_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [NHB-1:0] PWM_IN,
	input wire logic [NHB-1:0] HS_OVER,
	input wire logic [NHB-1:0] LS_OVER,
	input wire logic SUPPLY_OK,
	output logic [NHB-1:0] HS_GATE,
	output logic [NHB-1:0] LS_GATE,
	output logic [NHB-1:0] DISCHARGE,
	output logic [8:0] LOWSIDE_TRIP_LEVEL,
	output logic [8:0] HIGHSIDE_TRIP_LEVEL
);
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;
	logic [NHB-1:0] pwm_s;
	logic [NHB-1:0] hs_ov_s;
	logic [NHB-1:0] ls_ov_s;
	logic sup_s;
	logic [31:0] lowside_threshold_reg_q;
	logic [31:0] highside_threshold_reg_q;
	logic [11:0] ctrl_q;
	logic [31:0] deadtime_blank_cfg_q;
	logic [5:0] drain_fault_status_q;
	logic [5:0] drain_fault_status_d;
	logic [5:0] fault_set;
	logic [31:0] rd_val;
	logic mapped;
	logic access;
	logic wr_en;
	logic [1:0] trip_filter_sel;
	logic [TW-1:0] filt_len;
	logic [NHB-1:0] hs_mon;
	logic [NHB-1:0] ls_mon;
	logic [NHB-1:0] latched;

	// pins are asynchronous to CLK; only the second stage is read
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= {SUPPLY_OK, LS_OVER, HS_OVER, PWM_IN};
			sync_q <= meta_q;
		end
	end

	assign pwm_s = sync_q[2:0];
	assign hs_ov_s = sync_q[5:3];
	assign ls_ov_s = sync_q[8:6];
	assign sup_s = sync_q[9];

	assign access = PSEL && PENABLE;
	assign wr_en = access && PREADY && PWRITE;

	// one wait state so read data and ready both come from flops
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= access && !PREADY;
			if (access && !PREADY)
			begin
				PRDATA <= PWRITE ? 32'h00000000 : rd_val;
				PSLVERR <= !mapped;
			end
		end
	end

	always_comb
	begin
		mapped = 1'b1;
		case (PADDR)
			OFS_LS: rd_val = {21'h000000, lowside_threshold_reg_q[10:0]};
			OFS_HS: rd_val = {23'h000000, highside_threshold_reg_q[8:0]};
			OFS_CTRL: rd_val = {20'h00000, ctrl_q};
			OFS_CCP: rd_val = deadtime_blank_cfg_q;
			OFS_FAULT: rd_val = {26'h0000000, drain_fault_status_q};
			OFS_GSTAT: rd_val = {22'h000000, latched, LS_GATE, HS_GATE,
				|drain_fault_status_q};
			default:
			begin
				rd_val = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
	end

	// threshold codes go straight to the analog comparators
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			lowside_threshold_reg_q <= RST_LS;
			highside_threshold_reg_q <= RST_HS;
		end
		else if (wr_en && PADDR == OFS_LS)
			lowside_threshold_reg_q <= {21'h000000, PWDATA[10:0]};
		else if (wr_en && PADDR == OFS_HS)
			highside_threshold_reg_q <= {23'h000000, PWDATA[8:0]};
	end

	assign LOWSIDE_TRIP_LEVEL = lowside_threshold_reg_q[8:0];
	assign HIGHSIDE_TRIP_LEVEL = highside_threshold_reg_q[8:0];

	// timing is not guarded against live edits; software must hold pwm off
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl_q <= RST_CTRL;
			deadtime_blank_cfg_q <= RST_CCP;
		end
		else if (wr_en && PADDR == OFS_CTRL)
			ctrl_q <= PWDATA[11:0];
		else if (wr_en && PADDR == OFS_CCP)
			deadtime_blank_cfg_q <= PWDATA;
	end

	// write one to clear; a new fault in the same cycle wins
	always_comb
	begin
		drain_fault_status_d = drain_fault_status_q;
		if (wr_en && PADDR == OFS_FAULT)
			drain_fault_status_d = drain_fault_status_q & ~PWDATA[5:0];
		drain_fault_status_d = drain_fault_status_d | fault_set;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			drain_fault_status_q <= RST_FAULT;
		else
			drain_fault_status_q <= drain_fault_status_d;
	end

	assign trip_filter_sel = lowside_threshold_reg_q[FILT_LSB+1:FILT_LSB];

	always_comb
	begin
		unique case (trip_filter_sel)
			2'b00: filt_len = FILT0_CYC;
			2'b01: filt_len = FILT1_CYC;
			2'b10: filt_len = FILT2_CYC;
			2'b11: filt_len = FILT3_CYC;
		endcase
	end

	for (genvar x = 0; x < NHB; x++)
	begin : g_hb
		drive_t mode;
		logic pwm_en;
		logic afw;
		logic want_hs;
		logic want_ls;
		logic hs_q;
		logic ls_q;
		logic disch_q;
		logic hs_off;
		logic ls_off;
		logic hs_on;
		logic ls_on;
		logic off_pwm_fet;
		logic ccp_busy;
		logic hs_blk_busy;
		logic ls_blk_busy;
		logic [TW-1:0] ccp_len;
		logic [TW-1:0] blk_act;
		logic [TW-1:0] blk_fw;
		logic [TW-1:0] hs_flt_q;
		logic [TW-1:0] ls_flt_q;

		assign mode = drive_t'(ctrl_q[2*x+1:2*x]);
		assign pwm_en = ctrl_q[PWM_LSB+x];
		assign afw = ctrl_q[AFW_LSB+x];
		assign latched[x] = drain_fault_status_q[x] | drain_fault_status_q[HS_FLT_LSB+x]
			| fault_set[x] | fault_set[HS_FLT_LSB+x];

		// requested gate levels; only 01 and 10 ever turn a gate on
		always_comb
		begin
			want_hs = 1'b0;
			want_ls = 1'b0;
			unique case (mode)
				MODE_HS_ON:
				begin
					want_hs = pwm_en ? pwm_s[x] : 1'b1;
					want_ls = pwm_en && afw && !pwm_s[x];
				end
				MODE_LS_ON:
				begin
					want_ls = pwm_en ? pwm_s[x] : 1'b1;
					want_hs = pwm_en && afw && !pwm_s[x];
				end
				MODE_FLOAT, MODE_OFF:
				begin
					want_hs = 1'b0;
					want_ls = 1'b0;
				end
			endcase
			if (latched[x] || !sup_s)
			begin
				want_hs = 1'b0;
				want_ls = 1'b0;
			end
		end

		assign hs_off = hs_q && !want_hs;
		assign ls_off = ls_q && !want_ls;
		// a gate turns on only once the other is off and the dead time ran out
		assign hs_on = !hs_q && want_hs && !ls_q && !ccp_busy;
		assign ls_on = !ls_q && want_ls && !hs_q && !ccp_busy;

		// pwm gate going off hands over to the freewheel gate: freewheel dead time
		assign off_pwm_fet = pwm_en && afw && !latched[x] &&
			((hs_off && mode == MODE_HS_ON) || (ls_off && mode == MODE_LS_ON));
		assign ccp_len = off_pwm_fet ?
			interval_cycles(deadtime_blank_cfg_q[8*x+7:8*x+4]) :
			interval_cycles(deadtime_blank_cfg_q[8*x+3:8*x]);
		assign blk_act = interval_cycles(deadtime_blank_cfg_q[BLK_ACT_LSB+3:BLK_ACT_LSB]);
		assign blk_fw = interval_cycles(deadtime_blank_cfg_q[BLK_FW_LSB+3:BLK_FW_LSB]);

		interval_timer u_ccp (
			.clk(CLK),
			.rst(RST),
			.start(hs_off || ls_off),
			.len(ccp_len),
			.busy(ccp_busy)
		);

		// turn-on waits out any dead time, so blank always starts at turn-on;
		// from high impedance there is no dead time and it starts at once
		interval_timer u_hs_blk (
			.clk(CLK),
			.rst(RST),
			.start(hs_on),
			.len(mode == MODE_LS_ON ? blk_fw : blk_act),
			.busy(hs_blk_busy)
		);

		interval_timer u_ls_blk (
			.clk(CLK),
			.rst(RST),
			.start(ls_on),
			.len(mode == MODE_HS_ON ? blk_fw : blk_act),
			.busy(ls_blk_busy)
		);

		always_ff @(posedge CLK or posedge RST)
		begin
			if (RST)
			begin
				hs_q <= 1'b0;
				ls_q <= 1'b0;
			end
			else
			begin
				if (hs_off)
					hs_q <= 1'b0;
				else if (hs_on)
					hs_q <= 1'b1;
				if (ls_off)
					ls_q <= 1'b0;
				else if (ls_on)
					ls_q <= 1'b1;
			end
		end

		// comparators only count while the gate is on and past its blank
		assign hs_mon[x] = hs_q && !hs_blk_busy && hs_ov_s[x];
		assign ls_mon[x] = ls_q && !ls_blk_busy && ls_ov_s[x];

		always_ff @(posedge CLK or posedge RST)
		begin
			if (RST)
			begin
				hs_flt_q <= '0;
				ls_flt_q <= '0;
			end
			else
			begin
				hs_flt_q <= !hs_mon[x] ? '0 :
					(hs_flt_q == filt_len ? hs_flt_q : hs_flt_q + TW'(1));
				ls_flt_q <= !ls_mon[x] ? '0 :
					(ls_flt_q == filt_len ? ls_flt_q : ls_flt_q + TW'(1));
			end
		end

		// still above threshold after the full filter count means longer than it
		assign fault_set[HS_FLT_LSB+x] = hs_mon[x] && hs_flt_q == filt_len;
		assign fault_set[x] = ls_mon[x] && ls_flt_q == filt_len;

		// static discharge in mode 11, and for the dead time after a fault
		always_ff @(posedge CLK or posedge RST)
		begin
			if (RST)
				disch_q <= 1'b0;
			else
				disch_q <= mode == MODE_OFF || (latched[x] && (ccp_busy || hs_off || ls_off));
		end

		assign HS_GATE[x] = hs_q;
		assign LS_GATE[x] = ls_q;
		assign DISCHARGE[x] = disch_q;
	end
endmodule : gate_fault_supervisor

// ---- gate_fault_supervisor_assertions.sv ----
// port-level assertions for the gate fault supervisor
`timescale 1ns/1ps
module gate_fault_supervisor_assertions
	import gate_fault_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic PREADY,
	input wire logic SUPPLY_OK,
	input wire logic [NHB-1:0] HS_GATE,
	input wire logic [NHB-1:0] LS_GATE,
	input wire logic [NHB-1:0] DISCHARGE,
	input wire logic [8:0] LOWSIDE_TRIP_LEVEL,
	input wire logic [8:0] HIGHSIDE_TRIP_LEVEL
);
	// pready only rises inside an access phase, so it stands for a completed transfer
	wire logic wr = PREADY && PWRITE;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_no_overlap: assert property ((HS_GATE & LS_GATE) == '0)
		else $error("both gates of a bridge on");
	a_ls_hs_gap: assert property ($fell(LS_GATE[0]) |-> !HS_GATE[0] [*8])
		else $error("high side on inside dead time");
	a_hs_ls_gap: assert property ($fell(HS_GATE[0]) |-> !LS_GATE[0] [*8])
		else $error("low side on inside dead time");
	a_discharge_off: assert property ((DISCHARGE & (HS_GATE | LS_GATE)) == '0)
		else $error("discharge while gate on");
	a_trip_reset: assert property ($fell(RST) |->
		LOWSIDE_TRIP_LEVEL == 9'h049 && HIGHSIDE_TRIP_LEVEL == 9'h049)
		else $error("trip level reset value wrong");
	a_ls_write: assert property ($changed(LOWSIDE_TRIP_LEVEL) |->
		$past(wr) && $past(PADDR) == OFS_LS)
		else $error("low trip level changed without write");
	a_hs_write: assert property ($changed(HIGHSIDE_TRIP_LEVEL) |->
		$past(wr) && $past(PADDR) == OFS_HS)
		else $error("high trip level changed without write");
	a_supply_off: assert property (!SUPPLY_OK [*5] |-> (HS_GATE | LS_GATE) == '0)
		else $error("gate on with supply low");
endmodule : gate_fault_supervisor_assertions

// ---- bridge_model.sv ----
// half-bridge model: drain-source comparator per mosfet
`timescale 1ns/1ps
module bridge_model
	import gate_fault_pkg::*;
(
	input wire logic [NHB-1:0] hs_gate,
	input wire logic [NHB-1:0] ls_gate,
	input wire logic [NHB-1:0] hs_short,
	input wire logic [NHB-1:0] ls_short,
	output logic [NHB-1:0] hs_over,
	output logic [NHB-1:0] ls_over
);
	// an off fet facing an on one sees full supply, so the device must mask it
	assign hs_over = (hs_gate & hs_short) | (~hs_gate & ls_gate);
	assign ls_over = (ls_gate & ls_short) | (~ls_gate & hs_gate);
endmodule : bridge_model

// ---- test_gate_fault_supervisor.sv ----
// self-checking bench for the gate fault supervisor
`timescale 1ns/1ps
module test_gate_fault_supervisor
	import gate_fault_pkg::*;
();
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic SUPPLY_OK = 1'b1;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h00000000;
	logic [31:0] PRDATA, rdata, e;
	logic PREADY, PSLVERR;
	logic [NHB-1:0] PWM_IN = 3'h0;
	logic [NHB-1:0] hsf = 3'h0;
	logic [NHB-1:0] lsf = 3'h0;
	logic [NHB-1:0] HS_OVER, LS_OVER, HS_GATE, LS_GATE, DISCHARGE;
	logic [8:0] LOWSIDE_TRIP_LEVEL, HIGHSIDE_TRIP_LEVEL;
	logic [5:0] g;
	int fails = 0;
	int num_checks = 0;
	int cnt;
	assign g = {LS_GATE, HS_GATE};
	always #10 CLK = ~CLK;
	gate_fault_supervisor u_dut
	(
		.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PWM_IN(PWM_IN), .HS_OVER(HS_OVER), .LS_OVER(LS_OVER),
		.SUPPLY_OK(SUPPLY_OK), .HS_GATE(HS_GATE), .LS_GATE(LS_GATE), .DISCHARGE(DISCHARGE),
		.LOWSIDE_TRIP_LEVEL(LOWSIDE_TRIP_LEVEL), .HIGHSIDE_TRIP_LEVEL(HIGHSIDE_TRIP_LEVEL)
	);
	bridge_model u_bridge
	(
		.hs_gate(HS_GATE), .ls_gate(LS_GATE), .hs_short(hsf), .ls_short(lsf),
		.hs_over(HS_OVER), .ls_over(LS_OVER)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is sampled high, then an idle edge before the next
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rdata = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(rdata, exp);
	endtask : rd
	task automatic waitg(input int b, input logic v);
		cnt = 0;
		while (g[b] !== v && cnt < 400)
		begin
			@(posedge CLK);
			cnt++;
		end
		chk(g[b], v);
	endtask : waitg
	task automatic hold(input int n, input int b, input logic v);
		repeat (n)
		begin
			@(posedge CLK);
			chk(g[b], v);
		end
	endtask : hold
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#400000;
		fails++;
		complete_run();
	end
	initial
	begin
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd(OFS_LS, 32'h00000049);
		rd(OFS_HS, 32'h00000049);
		rd(OFS_CTRL, 32'h00000000);
		rd(OFS_CCP, 32'h00000000);
		rd(OFS_FAULT, 32'h00000000);
		chk({31'h0, PSLVERR}, 32'h00000000);
		rd(8'h18, 32'h00000000);
		chk({31'h0, PSLVERR}, 32'h00000001);
		for (int c = 0; c < 8; c++)
		begin
			e = {23'h0, {3{3'(c)}}};
			xfer(1'b1, OFS_LS, e);
			xfer(1'b1, OFS_HS, e);
			chk({23'h0, LOWSIDE_TRIP_LEVEL}, e);
			chk({23'h0, HIGHSIDE_TRIP_LEVEL}, e);
		end
		xfer(1'b1, OFS_LS, 32'h00000049);
		xfer(1'b1, OFS_HS, 32'h00000049);
		$display("test thresholds done");
		xfer(1'b1, OFS_CCP, 32'h0000000F);
		xfer(1'b1, OFS_CTRL, 32'h00000002);
		waitg(0, 1'b1);
		chk(32'(cnt < 4), 32'h00000001);
		xfer(1'b1, OFS_CTRL, 32'h00000001);
		waitg(0, 1'b0);
		waitg(3, 1'b1);
		chk(32'(cnt > 224 && cnt < 232), 32'h00000001);
		xfer(1'b1, OFS_CTRL, 32'h00000003);
		hold(240, 3, 1'b0);
		$display("test dead time done");
		hsf <= 3'h1;
		xfer(1'b1, OFS_CTRL, 32'h00000002);
		waitg(0, 1'b1);
		hold(40, 0, 1'b1);
		waitg(0, 1'b0);
		chk(32'(cnt < 30), 32'h00000001);
		@(posedge CLK);
		chk({31'h0, DISCHARGE[0]}, 32'h00000001);
		rd(OFS_FAULT, 32'h00000008);
		rd(OFS_GSTAT, 32'h00000081);
		hsf <= 3'h0;
		hold(300, 0, 1'b0);
		xfer(1'b1, OFS_FAULT, 32'h00000008);
		waitg(0, 1'b1);
		rd(OFS_FAULT, 32'h00000000);
		$display("test high side fault done");
		xfer(1'b1, OFS_CTRL, 32'h00000003);
		xfer(1'b1, OFS_LS, 32'h00000649);
		lsf <= 3'h1;
		xfer(1'b1, OFS_CTRL, 32'h00000001);
		waitg(3, 1'b1);
		hold(300, 3, 1'b1);
		waitg(3, 1'b0);
		chk(32'(cnt < 40), 32'h00000001);
		rd(OFS_FAULT, 32'h00000001);
		lsf <= 3'h0;
		xfer(1'b1, OFS_FAULT, 32'h00000001);
		rd(OFS_FAULT, 32'h00000000);
		xfer(1'b1, OFS_CTRL, 32'h00000000);
		xfer(1'b1, OFS_LS, 32'h00000049);
		xfer(1'b1, OFS_CCP, 32'h00000000);
		$display("test low side fault done");
		PWM_IN <= 3'h2;
		xfer(1'b1, OFS_CTRL, 32'h00000488);
		waitg(1, 1'b1);
		PWM_IN <= 3'h0;
		waitg(1, 1'b0);
		waitg(4, 1'b1);
		chk(32'(cnt > 25 && cnt < 33), 32'h00000001);
		PWM_IN <= 3'h2;
		waitg(4, 1'b0);
		waitg(1, 1'b1);
		chk(32'(cnt > 25 && cnt < 33), 32'h00000001);
		SUPPLY_OK <= 1'b0;
		waitg(1, 1'b0);
		hold(4, 1, 1'b0);
		SUPPLY_OK <= 1'b1;
		waitg(1, 1'b1);
		xfer(1'b1, OFS_CTRL, 32'h00000000);
		$display("test pwm and supply done");
		complete_run();
	end
endmodule : test_gate_fault_supervisor
bind gate_fault_supervisor gate_fault_supervisor_assertions u_chk
(
	.CLK(CLK), .RST(RST), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
	.SUPPLY_OK(SUPPLY_OK), .HS_GATE(HS_GATE), .LS_GATE(LS_GATE), .DISCHARGE(DISCHARGE),
	.LOWSIDE_TRIP_LEVEL(LOWSIDE_TRIP_LEVEL), .HIGHSIDE_TRIP_LEVEL(HIGHSIDE_TRIP_LEVEL)
);
